// ---- bench/dmc_load_model.sv ----
`default_nettype none
// winding current at the sense pin: only the trip crossing matters
module dmc_load_model (
   input wire logic ref_clk_i,
   input wire logic [3:0] sw_i,
   input wire logic [3:0] chg_i,
   input wire logic [7:0] level_i,
   output logic sense_o
);
   logic [7:0] amps_q = 8'h00;
   // saturating rise in charge, fall otherwise
   always_ff @(posedge ref_clk_i) begin
      if (sw_i == chg_i && amps_q != 8'hFF) amps_q <= amps_q + 8'h01;
      else if (sw_i != chg_i && amps_q != 8'h00) amps_q <= amps_q - 8'h01;
   end
   assign sense_o = amps_q >= level_i;
endmodule // dmc_load_model
`default_nettype wire

// ---- bench/dmc_props.sv ----
`default_nettype none
// port checker; six- and eight-cycle windows cover the input synchronisers
module dmc_props (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic bridge_gang_select_i,
   input wire logic chan_a_dir_first_i,
   input wire logic chan_a_dir_second_i,
   input wire logic chan_a_drive_gate_i,
   input wire logic chan_b_dir_first_i,
   input wire logic chan_b_dir_second_i,
   input wire logic chan_b_drive_gate_i,
   input wire logic overcurrent_shutdown_i,
   input wire logic [3:0] chan_a_switch_o,
   input wire logic [3:0] chan_b_switch_o,
   input wire logic standby_o,
   input wire logic fault_latched_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   // all six control pins low
   wire six_lo = !(chan_a_dir_first_i || chan_a_dir_second_i || chan_a_drive_gate_i
      || chan_b_dir_first_i || chan_b_dir_second_i || chan_b_drive_gate_i);
   sequence quiet_s; six_lo [*8]; endsequence
   sequence busy_s; !six_lo [*6]; endsequence
   sequence brake_s; (!bridge_gang_select_i && !chan_a_drive_gate_i
      && chan_a_dir_first_i && !fault_latched_o) [*8]; endsequence
   chk_idle_standby: assert property (quiet_s |-> standby_o)
      else $error("no standby");
   chk_standby_off: assert property (standby_o [*2] |-> !(chan_a_switch_o | chan_b_switch_o))
      else $error("standby drives");
   chk_fault_off: assert property (fault_latched_o [*2] |-> chan_a_switch_o == 4'h0)
      else $error("fault drives");
   chk_fault_set: assert property (overcurrent_shutdown_i [*8] |-> fault_latched_o)
      else $error("fault not latched");
   chk_fault_hold: assert property (busy_s ##0 fault_latched_o |=> fault_latched_o)
      else $error("fault lost");
   chk_legal_map: assert property (chan_a_switch_o inside {4'h0, 4'h3, 4'h6, 4'h9})
      else $error("bad switch set");
   chk_gang_copy: assert property (bridge_gang_select_i [*8] |-> chan_b_switch_o == chan_a_switch_o)
      else $error("gang differs");
   chk_gate_brake: assert property (brake_s |-> chan_a_switch_o == 4'h3)
      else $error("no brake");
endmodule // dmc_props
bind dmc_top dmc_props dmc_props_inst (.*);
`default_nettype wire

// ---- bench/tb_top.sv ----
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TICK = 10;
   logic clk = 1'b0, rst = 1'b1, osc = 1'b0, run = 1'b0, blk = 1'b0, sense;
   logic [6:0] ctl = 7'h00;
   logic [1:0] flt = 2'h0;
   logic [3:0] chg = 4'hF, sw_a, sw_b;
   logic stby, f_q;
   logic [7:0] n_c, n_f;
   int errors = 0, num_checks = 0, cyc = 0;
   // {gang, a dirs+gate, b dirs+gate, expected a, expected b, standby}
   logic [15:0] rows [8] = '{16'h0001, 16'h572C, 16'h3EC6, 16'h4866,
      16'h1200, 16'hD732, 16'hB8CC, 16'hE066};
   dmc_top dmc_top_inst (.ref_clk_i(clk), .sys_rst_i(rst), .chop_oscillator_i(osc),
      .bridge_gang_select_i(ctl[6]), .chan_a_dir_first_i(ctl[5]), .chan_a_dir_second_i(ctl[4]),
      .chan_a_drive_gate_i(ctl[3]), .chan_b_dir_first_i(ctl[2]), .chan_b_dir_second_i(ctl[1]),
      .chan_b_drive_gate_i(ctl[0]), .blank_length_select_i(blk), .chan_a_current_sense_i(sense),
      .chan_b_current_sense_i(1'b0), .overcurrent_shutdown_i(flt[0]),
      .thermal_shutdown_i(flt[1]), .chan_a_switch_o(sw_a), .chan_b_switch_o(sw_b),
      .standby_o(stby), .fault_latched_o(f_q));
   dmc_load_model dmc_load_model_inst (.ref_clk_i(clk), .sw_i(sw_a), .chg_i(chg),
      .level_i(8'h08), .sense_o(sense));
   // clock, and an oscillator that parks low when stopped
   initial forever #2.5 clk = ~clk;
   initial forever #25 osc = run & ~osc;
   // hang guard, well beyond the sixteen hundred cycles needed
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         errors++;
         final_report();
      end
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // two whole chop periods, so the phase of the window does not matter
   task automatic window(input logic [3:0] c, input logic [3:0] f);
      n_c = 8'h00;
      n_f = 8'h00;
      repeat (32 * TICK) begin
         @(posedge clk);
         n_c += 8'(sw_a === c);
         n_f += 8'(sw_a === f);
      end
      #1;
   endtask
   task automatic final_report();
      if (errors == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // table with oscillator parked, then chopping, then fault latch
   initial begin
      wait_clk(3);
      chk("reset", {stby, f_q, sw_a}, 8'h20);
      wait_clk(3);
      rst = 1'b0;
      foreach (rows[i]) begin
         ctl = rows[i][15:9];
         wait_clk(12);
         chk("switches", {sw_a, sw_b}, rows[i][8:1]);
         chk("standby", 8'(stby), 8'(rows[i][0]));
      end
      ctl = 7'h2B;
      run = 1'b1;
      for (int k = 0; k < 3; k++) begin
         blk = k[0];
         ctl[5:4] = k[1] ? 2'h1 : 2'h2;
         chg = k[1] ? 4'h6 : 4'h9;
         wait_clk(16 * TICK);
         window(chg, ~chg);
         chk("fast time", n_f, 8'(12 * TICK));
         chk("charge short", 8'(n_c < 2 * TICK * (blk ? 6 : 4) - 4), 8'h00);
         chk("charge long", 8'(n_c > 2 * TICK * (blk ? 6 : 4) + 20), 8'h00);
      end
      for (int k = 0; k < 2; k++) begin
         flt[k] = 1'b1;
         wait_clk(10);
         flt = 2'h0;
         wait_clk(10);
         chk("fault hold", {f_q, sw_a}, 8'h10);
         ctl = 7'h00;
         wait_clk(12);
         chk("fault clear", {f_q, stby}, 8'h01);
         ctl = 7'h2B;
      end
      final_report();
   end
endmodule // tb_top
`default_nettype wire

// ---- design/dmc_channel.sv ----
`default_nettype none
// one bridge: chopping sequencer, blanking and switch mapping
module dmc_channel (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic osc_tick_i,
   input wire logic dir_first_i,
   input wire logic dir_second_i,
   input wire logic drive_gate_i,
   input wire logic blank_long_i,
   input wire logic trip_i,
   input wire logic off_i,
   output logic [3:0] sw_o
);
   dmc_pkg::dmc_chop_t st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic [2:0] blk_q, blk_d;
   logic [1:0] dir_q, dir_d;
   logic [3:0] sw_q, sw_d;
   logic [3:0] base;
   logic drive;

   assign drive = drive_gate_i & (dir_first_i ^ dir_second_i);

   // sequencer, blanking counter and direction history
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      blk_d = blk_q;
      dir_d = {dir_first_i, dir_second_i};
      if (osc_tick_i) begin
         if (cnt_q == dmc_pkg::DMC_PERIOD_LAST) begin
            cnt_d = 4'h0;
            st_d = dmc_pkg::DMC_CHARGE;
            blk_d = blank_long_i ? dmc_pkg::DMC_BLANK_LONG : dmc_pkg::DMC_BLANK_SHORT;
         end else begin
            cnt_d = cnt_q + 4'h1;
            if (blk_q != 3'h0) begin
               blk_d = blk_q - 3'h1;
            end
            if (cnt_q == dmc_pkg::DMC_FAST_START && st_q != dmc_pkg::DMC_FAST) begin
               st_d = dmc_pkg::DMC_FAST;
            end
         end
      end
      // detection masked while blanking runs
      if (st_q == dmc_pkg::DMC_CHARGE && trip_i && blk_q == 3'h0 && st_d == st_q) begin
         st_d = dmc_pkg::DMC_SLOW;
      end
      if (dir_d != dir_q) begin
         blk_d = blank_long_i ? dmc_pkg::DMC_BLANK_LONG : dmc_pkg::DMC_BLANK_SHORT;
      end
   end

   // switch map for the forward direction, mirrored for reverse
   always_comb begin
      case (st_q)
         dmc_pkg::DMC_CHARGE: base = 4'h9;
         dmc_pkg::DMC_SLOW: base = 4'h3;
         default: base = 4'h6;
      endcase
      if (off_i) begin
         sw_d = dmc_pkg::DMC_SW_OFF;
      end else if (!drive) begin
         sw_d = (dir_first_i | dir_second_i) ? dmc_pkg::DMC_SW_BRAKE : dmc_pkg::DMC_SW_OFF;
      end else if (dir_first_i) begin
         sw_d = base;
      end else begin
         sw_d = {base[2], base[3], base[0], base[1]};
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q <= dmc_pkg::DMC_CHARGE;
         cnt_q <= 4'h0;
         blk_q <= 3'h0;
         dir_q <= 2'h0;
         sw_q <= 4'h0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         blk_q <= blk_d;
         dir_q <= dir_d;
         sw_q <= sw_d;
      end
   end
   assign sw_o = sw_q;
endmodule // dmc_channel
`default_nettype wire

// ---- design/dmc_top.sv ----
`default_nettype none
module dmc_top (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic chop_oscillator_i,
   input wire logic bridge_gang_select_i,
   input wire logic chan_a_dir_first_i,
   input wire logic chan_a_dir_second_i,
   input wire logic chan_a_drive_gate_i,
   input wire logic chan_b_dir_first_i,
   input wire logic chan_b_dir_second_i,
   input wire logic chan_b_drive_gate_i,
   input wire logic blank_length_select_i,
   input wire logic chan_a_current_sense_i,
   input wire logic chan_b_current_sense_i,
   input wire logic overcurrent_shutdown_i,
   input wire logic thermal_shutdown_i,
   output logic [3:0] chan_a_switch_o,
   output logic [3:0] chan_b_switch_o,
   output logic standby_o,
   output logic fault_latched_o
);
   // three-stage synchronisers for all pin inputs
   logic [13:0] s1_q, s2_q, s3_q, in_q, in_d;
   logic fault_q, fault_d, stby_q, stby_d, tick;
   logic a1, a2, ag, b1, b2, bg, gang, trip_a, trip_b, all_low, off;

   // a change counts once stages two and three agree
   always_comb begin
      in_d = in_q;
      for (int i = 0; i < 14; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            in_d[i] = s3_q[i];
         end
      end
   end

   // oscillator rising edge becomes a one-cycle tick
   assign tick = in_d[0] & ~in_q[0];
   assign gang = in_q[1];
   assign a1 = in_q[2];
   assign a2 = in_q[3];
   assign ag = in_q[4];
   // in ganged mode bridge B follows the A controls and both trip on either sense input
   assign b1 = gang ? a1 : in_q[5];
   assign b2 = gang ? a2 : in_q[6];
   assign bg = gang ? ag : in_q[7];
   assign trip_a = gang ? (in_q[9] | in_q[10]) : in_q[9];
   assign trip_b = gang ? trip_a : in_q[10];
   assign all_low = ~(in_q[2] | in_q[3] | in_q[4] | in_q[5] | in_q[6] | in_q[7]);

   // fault latch: the new fault wins over the clearing condition
   always_comb begin
      fault_d = fault_q;
      if (all_low) begin
         fault_d = 1'b0;
      end
      if (in_q[11] | in_q[12]) begin
         fault_d = 1'b1;
      end
      stby_d = all_low | fault_d;
   end
   assign off = stby_q;

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s1_q <= 14'h0000;
         s2_q <= 14'h0000;
         s3_q <= 14'h0000;
         in_q <= 14'h0000;
         fault_q <= 1'b0;
         stby_q <= 1'b1;
      end else begin
         s1_q <= {1'b0, thermal_shutdown_i, overcurrent_shutdown_i,
            chan_b_current_sense_i, chan_a_current_sense_i, blank_length_select_i,
            chan_b_drive_gate_i, chan_b_dir_second_i, chan_b_dir_first_i,
            chan_a_drive_gate_i, chan_a_dir_second_i, chan_a_dir_first_i,
            bridge_gang_select_i, chop_oscillator_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
         in_q <= in_d;
         fault_q <= fault_d;
         stby_q <= stby_d;
      end
   end

   // both channels share the oscillator, so ganged halves stay in step
   dmc_channel u_chan_a (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .osc_tick_i(tick),
      .dir_first_i(a1),
      .dir_second_i(a2),
      .drive_gate_i(ag),
      .blank_long_i(in_q[8]),
      .trip_i(trip_a),
      .off_i(off),
      .sw_o(chan_a_switch_o)
   );

   dmc_channel u_chan_b (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .osc_tick_i(tick),
      .dir_first_i(b1),
      .dir_second_i(b2),
      .drive_gate_i(bg),
      .blank_long_i(in_q[8]),
      .trip_i(trip_b),
      .off_i(off),
      .sw_o(chan_b_switch_o)
   );

   assign standby_o = stby_q;
   assign fault_latched_o = fault_q;
endmodule // dmc_top
`default_nettype wire

// ---- shared/dmc_pkg.sv ----
`default_nettype none
package dmc_pkg;
   // chopping period in oscillator ticks and the decay switch point
   localparam logic [3:0] DMC_PERIOD_LAST = 4'hF; // 16 ticks per period
   // the tick that starts the period is the first, so the eleventh moves 9 to 10;
   // fast decay then covers counts 10..15, six of sixteen ticks
   localparam logic [3:0] DMC_FAST_START = 4'h9; // rising edge of 11th tick
   localparam logic [2:0] DMC_BLANK_SHORT = 3'h4;
   localparam logic [2:0] DMC_BLANK_LONG = 3'h6;
   localparam logic [3:0] DMC_SW_OFF = 4'h0;
   // switch vector order {high_one, high_two, low_one, low_two}
   localparam logic [3:0] DMC_SW_BRAKE = 4'h3;
   typedef enum logic [2:0] {
      DMC_CHARGE = 3'h1,
      DMC_SLOW = 3'h2,
      DMC_FAST = 3'h4
   } dmc_chop_t;
endpackage
`default_nettype wire
